// File: hbp_ctrl.sv
/*
  Control and protection logic of one power half-bridge: decodes sleep and
  side-select into switch enables with dead time, drives the diagnostic flag,
  and handles voltage, thermal, short and current-limit faults. Registers sit
  on an AXI4-Lite slave. Assumes fault detectors deliver asynchronous levels.
*/
// Overview of operation
// - Sleep low, no overvoltage: both switches off, diag low
// - Sleep low clears thermal and short latches
// - Side low enables lower, high enables upper
// - Normal: diag reports current of enabled switch
// - Overvoltage, low current: upper on, diag high
// - Overvoltage, high current: lock off until sleep low with supply back in range
// - Undervoltage: both off, diag low, inputs ignored
// - Thermal or short fault: latch off, diag high
// - Diag high means error to host
// - Overcurrent: limit mode, retry after cooldown
// - Limit mode swaps switches, diag high
// - Resume after cooldown, clear error after two
// - Dead time keeps switches never on together
module hbp_ctrl #(
  parameter int DEAD_CYCLES = hbp_pkg::DEAD_CYCLES_DEF,
  parameter int COOL_CYCLES = hbp_pkg::COOL_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_n,
  input wire logic side_sel,
  input wire logic overvolt_guard,
  input wire logic undervolt_guard,
  input wire logic over_temp,
  input wire logic short_upper,
  input wire logic short_lower,
  input wire logic over_limit,
  output logic upper_switch,
  output logic lower_switch,
  output logic sense_diag_out,
  output logic sense_mode,
  output logic sense_upper,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  hbp_pkg::hbp_pins_t pins_raw;
  hbp_pkg::hbp_pins_t pins;

  assign pins_raw = '{sleep_n, side_sel, overvolt_guard, undervolt_guard,
                      over_temp, short_upper, short_lower, over_limit};

  hbp_sync #(
    .WIDTH($bits(hbp_pkg::hbp_pins_t))
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(pins_raw),
    .sync_out(pins)
  );

  // ----------------------------------------------------------------------
  // Protection state
  // ----------------------------------------------------------------------
  localparam logic [hbp_pkg::CNT_W-1:0] COOL_ONE = hbp_pkg::CNT_W'(COOL_CYCLES);
  localparam logic [hbp_pkg::CNT_W-1:0] COOL_LAST = hbp_pkg::CNT_W'(2 * COOL_CYCLES - 1);

  hbp_pkg::hbp_mode_t mode;
  hbp_pkg::hbp_mode_t next_mode;
  logic fault_latch;
  logic ov_lock;
  logic [hbp_pkg::CNT_W-1:0] cl_cnt;
  logic fault_now;
  logic limit_start;
  logic limit_phase;
  logic err_hold;

  assign fault_now = pins.over_temp | pins.short_upper | pins.short_lower;
  // A trip restarts the cycle only outside the switched phase
  assign limit_start = pins.over_limit && (cl_cnt == '0 || cl_cnt >= COOL_ONE);
  assign limit_phase = limit_start || (cl_cnt != '0 && cl_cnt < COOL_ONE);
  assign err_hold = cl_cnt != '0;

  // Fault priority: supply faults override the sleep input
  always_comb begin
    if (pins.undervolt_guard) begin
      next_mode = hbp_pkg::HBP_UV;
    end else if (ov_lock || (pins.overvolt_guard && pins.over_limit)) begin
      next_mode = hbp_pkg::HBP_OV_LOCK;
    end else if (pins.overvolt_guard) begin
      next_mode = hbp_pkg::HBP_OV_UP;
    end else if (!pins.sleep_n) begin
      next_mode = hbp_pkg::HBP_STANDBY;
    end else if (fault_latch || fault_now) begin
      next_mode = hbp_pkg::HBP_LATCH;
    end else if (limit_phase) begin
      next_mode = hbp_pkg::HBP_LIMIT;
    end else begin
      next_mode = hbp_pkg::HBP_NORMAL;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= hbp_pkg::HBP_STANDBY;
    end else begin
      mode <= next_mode;
    end
  end

  // Thermal and short latch, only sleep low releases it
  always_ff @(posedge aclk) begin
    if (!aresetn || !pins.sleep_n) begin
      fault_latch <= 1'b0;
    end else if (fault_now) begin
      fault_latch <= 1'b1;
    end
  end

  // Overvoltage lock: freed at sleep low once the supply is back in range
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ov_lock <= 1'b0;
    end else if (pins.overvolt_guard && pins.over_limit) begin
      ov_lock <= 1'b1;
    end else if (!pins.sleep_n && !pins.overvolt_guard) begin
      ov_lock <= 1'b0;
    end
  end

  // Cooldown counter: switched phase for one interval, error for two
  always_ff @(posedge aclk) begin
    if (!aresetn || !pins.sleep_n || pins.undervolt_guard) begin
      cl_cnt <= '0;
    end else if (limit_start) begin
      cl_cnt <= hbp_pkg::CNT_W'(1);
    end else if (cl_cnt == COOL_LAST) begin
      cl_cnt <= '0;
    end else if (cl_cnt != '0) begin
      cl_cnt <= cl_cnt + hbp_pkg::CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // Switch requests and diagnostic flag
  // ----------------------------------------------------------------------
  logic req_up;
  logic req_lo;
  logic next_diag;

  always_comb begin
    unique case (mode)
      hbp_pkg::HBP_NORMAL: begin
        req_up = pins.side_sel;
        req_lo = !pins.side_sel;
        next_diag = err_hold;
      end
      hbp_pkg::HBP_LIMIT: begin
        req_up = !pins.side_sel;
        req_lo = pins.side_sel;
        next_diag = 1'b1;
      end
      hbp_pkg::HBP_OV_UP: begin
        req_up = 1'b1;
        req_lo = 1'b0;
        next_diag = 1'b1;
      end
      hbp_pkg::HBP_OV_LOCK, hbp_pkg::HBP_LATCH: begin
        req_up = 1'b0;
        req_lo = 1'b0;
        next_diag = 1'b1;
      end
      hbp_pkg::HBP_STANDBY, hbp_pkg::HBP_UV: begin
        req_up = 1'b0;
        req_lo = 1'b0;
        next_diag = 1'b0;
      end
      default: begin
        req_up = 1'b0;
        req_lo = 1'b0;
        next_diag = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Dead-time driver
  // ----------------------------------------------------------------------
  logic [7:0] dead_cfg;
  logic [7:0] dt_cnt;
  logic drop_now;

  // Any enabled switch no longer requested goes off at once
  assign drop_now = (upper_switch && !req_up) || (lower_switch && !req_lo);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upper_switch <= 1'b0;
      lower_switch <= 1'b0;
      dt_cnt <= '0;
    end else if (drop_now) begin
      upper_switch <= 1'b0;
      lower_switch <= 1'b0;
      dt_cnt <= dead_cfg;
    end else if (dt_cnt != '0) begin
      dt_cnt <= dt_cnt - 8'h01;
    end else begin
      upper_switch <= req_up;
      lower_switch <= req_lo;
    end
  end

  // Diagnostic outputs; sense mode only in clean normal operation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_diag_out <= 1'b0;
      sense_mode <= 1'b0;
      sense_upper <= 1'b0;
    end else begin
      sense_diag_out <= next_diag;
      sense_mode <= mode == hbp_pkg::HBP_NORMAL && !err_hold;
      sense_upper <= req_up;
    end
  end

  // ----------------------------------------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------------------------------------
  logic [hbp_pkg::EV_W-1:0] status;
  logic [hbp_pkg::EV_W-1:0] mask;
  logic [hbp_pkg::EV_W-1:0] ev;
  logic [hbp_pkg::EV_W-1:0] st_clr;
  logic entering;

  assign entering = next_mode != mode;
  assign ev[hbp_pkg::EV_UNDERVOLT] = entering && next_mode == hbp_pkg::HBP_UV;
  assign ev[hbp_pkg::EV_OVERVOLT] = entering && next_mode == hbp_pkg::HBP_OV_UP;
  assign ev[hbp_pkg::EV_OV_LOCK] = entering && next_mode == hbp_pkg::HBP_OV_LOCK;
  assign ev[hbp_pkg::EV_FAULT_LATCH] = entering && next_mode == hbp_pkg::HBP_LATCH;
  assign ev[hbp_pkg::EV_LIMIT] = entering && next_mode == hbp_pkg::HBP_LIMIT;
  assign irq = |(status & mask);

  // New events win over a clearing read in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= hbp_pkg::STATUS_RESET;
    end else begin
      status <= (status & ~st_clr) | ev;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  logic aw_got;
  logic w_got;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic do_read;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;
  logic [31:0] state_word;

  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_got && w_got && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign wr_hit = aw_addr == hbp_pkg::OFS_MASK || aw_addr == hbp_pkg::OFS_DEADTIME
                  || aw_addr == hbp_pkg::OFS_STATUS || aw_addr == hbp_pkg::OFS_STATE;
  assign rd_hit = s_axi_araddr == hbp_pkg::OFS_MASK || s_axi_araddr == hbp_pkg::OFS_DEADTIME
                  || s_axi_araddr == hbp_pkg::OFS_STATUS || s_axi_araddr == hbp_pkg::OFS_STATE;
  assign st_clr = (do_read && s_axi_araddr == hbp_pkg::OFS_STATUS) ? '1 : '0;

  assign state_word = {24'h0000_00, pins.side_sel, pins.sleep_n, sense_diag_out,
                       lower_switch, upper_switch, mode};
  assign rd_word = s_axi_araddr == hbp_pkg::OFS_STATUS ? {27'h000_0000, status}
                 : s_axi_araddr == hbp_pkg::OFS_MASK ? {27'h000_0000, mask}
                 : s_axi_araddr == hbp_pkg::OFS_STATE ? state_word
                 : s_axi_araddr == hbp_pkg::OFS_DEADTIME ? {24'h0000_00, dead_cfg}
                 : 32'h0000_0000;

  // Address and data captured in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= {s_axi_awaddr[3:2], 2'b00};
      end else if (do_write) begin
        aw_got <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_got <= 1'b0;
      end
    end
  end

  // Writable registers; STATUS and STATE ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= hbp_pkg::MASK_RESET;
      dead_cfg <= 8'(DEAD_CYCLES);
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == hbp_pkg::OFS_MASK) begin
        mask <= w_data[hbp_pkg::EV_W-1:0];
      end
      if (aw_addr == hbp_pkg::OFS_DEADTIME) begin
        dead_cfg <= w_data[7:0];
      end
    end
  end

  // Write response, low address bits dropped so every write answers OKAY
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= hbp_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? hbp_pkg::RESP_OKAY : hbp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data registered, one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= hbp_pkg::RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? hbp_pkg::RESP_OKAY : hbp_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_side_high_normal;
    mode == hbp_pkg::HBP_NORMAL && pins.side_sel;
  endsequence

  a_never_both: assert property (@(posedge aclk) disable iff (!aresetn)
    !(upper_switch && lower_switch))
    else $error("both switches enabled");

  a_sleep_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == hbp_pkg::HBP_STANDBY |=> !upper_switch && !lower_switch && !sense_diag_out)
    else $error("standby not quiet");

  a_sleep_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    !pins.sleep_n |=> !fault_latch)
    else $error("latch survived sleep");

  a_side_lower: assert property (@(posedge aclk) disable iff (!aresetn)
    s_side_high_normal [*2] |-> !lower_switch)
    else $error("lower on with side high");

  a_normal_sense: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == hbp_pkg::HBP_NORMAL && !err_hold |=> sense_mode && !sense_diag_out)
    else $error("normal mode not sensing");

  a_ov_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == hbp_pkg::HBP_OV_UP |=> !lower_switch && sense_diag_out)
    else $error("overvoltage drive wrong");

  a_ov_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    ov_lock && pins.sleep_n |=> ov_lock)
    else $error("overvoltage lock lost");

  a_uv_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == hbp_pkg::HBP_UV |=> !upper_switch && !lower_switch && !sense_diag_out)
    else $error("undervoltage not locked");

  a_latch_off: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == hbp_pkg::HBP_LATCH |=> !upper_switch && !lower_switch && sense_diag_out)
    else $error("fault latch outputs wrong");

  a_limit_error: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == hbp_pkg::HBP_NORMAL && $rose(err_hold) == 1'b0 && err_hold
      |=> sense_diag_out)
    else $error("error flag dropped early");

  a_limit_ends: assert property (@(posedge aclk) disable iff (!aresetn)
    cl_cnt == COOL_LAST && !pins.over_limit && pins.sleep_n |=> cl_cnt == '0)
    else $error("cooldown did not end");

endmodule // hbp_ctrl

// File: hbp_host_model.sv
/*
  Host model: drives the sleep and side-select pins, reads the diag flag.
  Assumes one clock shared with the block; pins change after rising edges.
*/
module hbp_host_model (
  input wire logic aclk,
  input wire logic want_sleep_n,
  input wire logic want_side,
  input wire logic diag,
  output logic sleep_n,
  output logic side_sel,
  output logic error_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  // -------------------------------------------------------------------
  // Pin drive
  // -------------------------------------------------------------------
  // Pins follow the wishes one edge late; sleep low is the latch clear
  always_ff @(posedge aclk) begin
    sleep_n <= want_sleep_n;
    side_sel <= want_side;
  end
  // A high diag level is taken as an error
  assign error_seen = diag;
endmodule // hbp_host_model

// File: hbp_pkg.sv
/*
  Shared constants and types of the half-bridge protection control block:
  register map, reset values, timing counts, mode encoding and pin bundle.
  Assumes a single 10 MHz clock and an AXI4-Lite register bus of 32 bits.
*/
package hbp_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int LIMIT_COOLDOWN_TIME_NS = 140000;
  // Typical figure, taken as exact; 1400 cycles at 10 MHz
  localparam int COOL_CYCLES = (LIMIT_COOLDOWN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_CYCLES_DEF = 4;
  localparam int CNT_W = 12;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_MASK = 4'h4;
  localparam logic [3:0] OFS_STATE = 4'h8;
  localparam logic [3:0] OFS_DEADTIME = 4'hc;
  localparam int EV_W = 5;
  localparam logic [EV_W-1:0] MASK_RESET = 5'h00;
  localparam logic [EV_W-1:0] STATUS_RESET = 5'h00;
  // Event bit positions in STATUS and MASK
  localparam int EV_UNDERVOLT = 0;
  localparam int EV_OVERVOLT = 1;
  localparam int EV_OV_LOCK = 2;
  localparam int EV_FAULT_LATCH = 3;
  localparam int EV_LIMIT = 4;
  // STATE field positions
  localparam int ST_MODE_LSB = 0;
  localparam int ST_UPPER = 3;
  localparam int ST_LOWER = 4;
  localparam int ST_DIAG = 5;
  localparam int ST_SLEEP_N = 6;
  localparam int ST_SIDE = 7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // Gray codes along standby - normal - limit - latch - ov
  typedef enum logic [2:0] {
    HBP_STANDBY = 3'b000,
    HBP_NORMAL = 3'b001,
    HBP_LIMIT = 3'b011,
    HBP_LATCH = 3'b010,
    HBP_OV_UP = 3'b110,
    HBP_OV_LOCK = 3'b111,
    HBP_UV = 3'b101
  } hbp_mode_t;

  // Pin inputs as one bundle, synchronised together
  typedef struct packed {
    logic sleep_n;
    logic side_sel;
    logic overvolt_guard;
    logic undervolt_guard;
    logic over_temp;
    logic short_upper;
    logic short_lower;
    logic over_limit;
  } hbp_pins_t;

endpackage

// File: hbp_sync.sv
/*
  Two-stage synchroniser for a bundle of asynchronous pin levels.
  Assumes levels that are stable for several clock periods.
*/
module hbp_sync #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // hbp_sync

// File: tb.sv
/*
  Self-checking bench of hbp_ctrl: sleep and side pins via the host model, registers
  over AXI4-Lite. Assumes short cooldown (20) and dead time (4) cycles.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ov, uv, ol;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] bresp, rresp, resp;
  logic want_sleep_n, want_side, sleep_n, side_sel, error_seen;
  logic [2:0] flt;
  logic upper_switch, lower_switch, sense_diag_out, sense_mode, sense_upper, irq;
  logic [31:0] seed = 32'h0001_0636;
  int num_errors = 0;
  int n_checks = 0;

  // Slow 10 MHz clock
  always #50 aclk = ~aclk;

  hbp_host_model hbp_host_model_inst (.aclk(aclk), .want_sleep_n(want_sleep_n),
    .want_side(want_side), .diag(sense_diag_out), .sleep_n(sleep_n),
    .side_sel(side_sel), .error_seen(error_seen));

  hbp_ctrl #(.DEAD_CYCLES(4), .COOL_CYCLES(20)) hbp_ctrl_inst (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sleep_n(sleep_n), .side_sel(side_sel), .overvolt_guard(ov),
    .undervolt_guard(uv), .over_temp(flt[0]), .short_upper(flt[1]),
    .short_lower(flt[2]), .over_limit(ol), .upper_switch(upper_switch),
    .lower_switch(lower_switch), .sense_diag_out(sense_diag_out),
    .sense_mode(sense_mode), .sense_upper(sense_upper), .irq(irq));

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Outputs compared as {upper, lower, diag}
  task automatic check_out(input string name, input logic [2:0] exp);
    n_checks++;
    if ({upper_switch, lower_switch, sense_diag_out} !== exp) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", name, exp,
        {upper_switch, lower_switch, sense_diag_out});
    end
  endtask

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [2:0] normal_out(input logic side);
    return {side, ~side, 1'b0};
  endfunction

  // Current limit drives the switch opposite to the request
  function automatic logic [2:0] limit_out(input logic side);
    return {~side, side, 1'b1};
  endfunction

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Pins need 4 edges plus dead time; sample mid-cycle
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  // Ready sampled at the falling edge is the level seen at the next rise
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    int n;
    logic aw_ok, w_ok, b_ok;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_ok = 1'b0;
    n = 0;
    while (!b_ok && n < 64) begin
      @(negedge aclk);
      aw_ok = awvalid & awready;
      w_ok = wvalid & wready;
      b_ok = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
    int n;
    logic ar_ok, r_ok;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_ok = 1'b0;
    n = 0;
    while (!r_ok && n < 64) begin
      @(negedge aclk);
      ar_ok = arvalid & arready;
      r_ok = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
  endtask

  // Shoot-through guard watched every cycle
  always @(negedge aclk) begin
    if (upper_switch === 1'b1 && lower_switch === 1'b1) begin
      num_errors++;
      $display("wrong value overlap expected 0 seen 1");
    end
  end

  // Run is about 600 cycles; over thirty times that means a hang
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    complete_run();
  end

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    aresetn <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, ov, uv, ol} <= 8'h00;
    {want_sleep_n, want_side, flt} <= 5'h00;
    awaddr <= 4'h0;
    araddr <= 4'h0;
    wdata <= 32'h0000_0000;
    wstrb <= 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(hbp_pkg::OFS_MASK, rv);
    check_val("mask reset", 32'h0000_0000, rv);
    axi_read(hbp_pkg::OFS_DEADTIME, rv);
    check_val("dead reset", 32'h0000_0004, rv);
    check_val("rresp", {30'h0000_0000, hbp_pkg::RESP_OKAY}, {30'h0000_0000, resp});
    // Unaligned read address is unmapped: error response, zero data
    axi_read(4'h2, rv);
    check_val("bad rdata", 32'h0000_0000, rv);
    check_val("bad rresp", {30'h0000_0000, hbp_pkg::RESP_SLVERR}, {30'h0000_0000, resp});
    axi_write(hbp_pkg::OFS_MASK, xs() & 32'h0000_001f);
    check_val("bresp", {30'h0000_0000, hbp_pkg::RESP_OKAY}, {30'h0000_0000, resp});
    axi_read(hbp_pkg::OFS_MASK, rv);
    check_val("mask rw", seed & 32'h0000_001f, rv);
    @(posedge aclk);
    want_side <= 1'b1;
    settle(12);
    check_out("sleep", 3'b000);
    @(posedge aclk);
    want_sleep_n <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(posedge aclk);
      want_side <= (i == 0) ? 1'b0 : 1'(xs());
      settle(12);
      check_out("drive", normal_out(want_side));
      check_val("sense", {30'h0000_0000, 1'b1, want_side}, {30'h0000_0000, sense_mode, sense_upper});
    end
    // Over-voltage with low current, seen through status and irq
    axi_read(hbp_pkg::OFS_STATUS, rv);
    axi_write(hbp_pkg::OFS_MASK, 32'h0000_0002);
    @(posedge aclk);
    ov <= 1'b1;
    settle(12);
    check_out("ov up", 3'b101);
    check_val("irq set", 32'h0000_0001, {31'h0000_0000, irq});
    axi_read(hbp_pkg::OFS_STATUS, rv);
    check_val("status", 32'h0000_0002, rv);
    @(negedge aclk);
    check_val("irq clear", 32'h0000_0000, {31'h0000_0000, irq});
    @(posedge aclk);
    ol <= 1'b1;
    settle(12);
    check_out("ov lock", 3'b001);
    axi_read(hbp_pkg::OFS_STATE, rv);
    check_val("state", {24'h0000_00, want_side, 2'b11, 2'b00, hbp_pkg::HBP_OV_LOCK}, rv);
    @(posedge aclk);
    {ov, ol} <= 2'b00;
    settle(12);
    check_out("ov held", 3'b001);
    @(posedge aclk);
    want_sleep_n <= 1'b0;
    settle(12);
    @(posedge aclk);
    want_sleep_n <= 1'b1;
    settle(12);
    check_out("ov reset", normal_out(want_side));
    @(posedge aclk);
    uv <= 1'b1;
    want_side <= ~want_side;
    settle(12);
    check_out("uv", 3'b000);
    @(posedge aclk);
    uv <= 1'b0;
    settle(12);
    check_out("uv gone", normal_out(want_side));
    // Each latched fault, then cleared by sleep
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      flt <= 3'b001 << i;
      settle(12);
      check_out("fault", 3'b001);
      check_val("err flag", 32'h0000_0001, {31'h0000_0000, error_seen});
      @(posedge aclk);
      flt <= 3'b000;
      settle(12);
      check_out("latched", 3'b001);
      @(posedge aclk);
      want_sleep_n <= 1'b0;
      settle(12);
      check_out("standby", 3'b000);
      @(posedge aclk);
      want_sleep_n <= 1'b1;
      settle(12);
      check_out("cleared", normal_out(want_side));
    end
    // Limit pulse: swap, resume after 20, diag clear after 40
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      want_side <= i[0];
      settle(12);
      @(posedge aclk);
      ol <= 1'b1;
      repeat (5) @(posedge aclk);
      ol <= 1'b0;
      settle(5);
      check_out("limit", limit_out(want_side));
      settle(22);
      check_out("resume", normal_out(want_side) | 3'b001);
      settle(18);
      check_out("diag clear", normal_out(want_side));
    end
    complete_run();
  end
endmodule // tb
